// ### core/pofr_cfg_if.sv
`default_nettype none
interface pofr_cfg_if;
	logic parity_dis;
	logic pulse_six;
	logic [1:0] wm_high;
	logic [1:0] wm_low;
	modport src (output parity_dis, output pulse_six, output wm_high, output wm_low);
	modport dst (input parity_dis, input pulse_six, input wm_high, input wm_low);
endinterface : pofr_cfg_if
`default_nettype wire

// ### core/pofr_coll_count.sv
`default_nettype none
module pofr_coll_count (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Configuration
	pofr_cfg_if.dst cfg,
	// Subcarrier pulses
	input wire logic bit_window_i,
	input wire logic sub_pulse_i,
	output logic coll_err_o,
	output logic coll_evt_o
);
	import pofr_pkg::*;

	typedef struct packed {
		logic [2:0] cnt;
		logic err;
		logic evt;
	} pofr_coll_state_type;

	pofr_coll_state_type st;
	pofr_coll_state_type next_st;
	logic [2:0] limit;

	always_comb begin
		next_st = st;
		limit = cfg.pulse_six ? COLL_PULSES_SIX : COLL_PULSES_SEVEN;
		next_st.evt = 1'b0;
		if (bit_window_i) begin
			next_st.cnt = '0;
			next_st.err = 1'b0;
		end else if (sub_pulse_i && st.cnt < limit) begin
			next_st.cnt = st.cnt + 3'h1;
			if (next_st.cnt == limit) begin
				next_st.err = 1'b1;
				next_st.evt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign coll_err_o = st.err;
	assign coll_evt_o = st.evt;

	AST_COLL_COUNT: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(coll_err_o) |-> st.cnt == (cfg.pulse_six ? COLL_PULSES_SIX : COLL_PULSES_SEVEN))
		else $error("Collision error at wrong pulse count");
endmodule : pofr_coll_count
`default_nettype wire

// ### core/pofr_fifo_level.sv
`default_nettype none
module pofr_fifo_level (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Configuration
	pofr_cfg_if.dst cfg,
	// FIFO state
	input wire logic rx_busy_i,
	input wire logic tx_busy_i,
	input wire logic [7:0] fifo_count_i,
	output logic fifo_evt_o
);
	import pofr_pkg::*;

	typedef struct packed {
		logic above;
		logic below;
		logic evt;
	} pofr_level_state_type;

	pofr_level_state_type st;
	pofr_level_state_type next_st;

	function automatic logic [7:0] high_level(input logic [1:0] code);
		case (code)
			2'h0: high_level = WM_HIGH_0;
			2'h1: high_level = WM_HIGH_1;
			2'h2: high_level = WM_HIGH_2;
			default: high_level = WM_HIGH_3;
		endcase
	endfunction : high_level

	function automatic logic [7:0] low_level(input logic [1:0] code);
		case (code)
			2'h0: low_level = WM_LOW_0;
			2'h1: low_level = WM_LOW_1;
			2'h2: low_level = WM_LOW_2;
			default: low_level = WM_LOW_3;
		endcase
	endfunction : low_level

	always_comb begin
		next_st = st;
		next_st.above = rx_busy_i && (fifo_count_i >= high_level(cfg.wm_high));
		next_st.below = tx_busy_i && (fifo_count_i <= low_level(cfg.wm_low));
		next_st.evt = (next_st.above && !st.above) || (next_st.below && !st.below);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign fifo_evt_o = st.evt;

	AST_WM_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx_busy_i && fifo_count_i >= high_level(cfg.wm_high) && !st.above) |=> fifo_evt_o)
		else $error("FIFO high level crossing gave no event");
	AST_WM_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(fifo_evt_o) |-> $past(rx_busy_i && fifo_count_i >= high_level(cfg.wm_high))
		|| $past(tx_busy_i && fifo_count_i <= low_level(cfg.wm_low)))
		else $error("FIFO event without a level crossing");
endmodule : pofr_fifo_level
`default_nettype wire

// ### core/pofr_pkg.sv
`default_nettype none
package pofr_pkg;
	// Register indices, byte address is four times the index
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h0C;
	localparam logic [5:0] IDX_PROTO_OPT = 6'h10;
	localparam logic [5:0] IDX_RX_MIRROR = 6'h11;
	localparam logic [5:0] IDX_FIFO_THRESH = 6'h14;
	localparam logic [5:0] IDX_IRQ_CLEAR = 6'h1A;
	localparam logic [5:0] IDX_IRQ_ENABLE = 6'h1B;

	// Protocol option fields
	localparam int PO_PARITY_DIS = 5;
	localparam int PO_SLOT_GRID = 4;
	localparam int PO_RAW_TX = 3;
	localparam int PO_SHORT_REPLY = 2;
	localparam int PO_PLAIN_FRAMING = 1;
	localparam int PO_PULSE_SIX = 0;
	localparam logic [7:0] PO_WRITE_MASK = 8'h3F;
	localparam logic [7:0] PO_RESET = 8'h00;

	// FIFO threshold fields
	localparam int FT_HIGH_LSB = 2;
	localparam int FT_LOW_LSB = 0;
	localparam logic [7:0] FT_WRITE_MASK = 8'h0F;
	localparam logic [7:0] FT_RESET = 8'h00;

	// Interrupt status layout
	localparam int ST_TX_END = 7;
	localparam int ST_RX_START = 6;
	localparam int ST_FIFO = 5;
	localparam int ST_RX_END = 4;
	localparam int ST_COLL = 3;
	localparam int ST_PARITY = 2;
	localparam logic [7:0] ST_RESET = 8'h00;
	localparam logic [7:0] IRQ_EN_RESET = 8'h00;
	localparam logic [7:0] IRQ_GATE_MASK = 8'hBC;
	localparam int MIRROR_BIT = 0;

	// Collision pulse thresholds
	localparam logic [2:0] COLL_PULSES_SEVEN = 3'h7;
	localparam logic [2:0] COLL_PULSES_SIX = 3'h6;

	// FIFO levels in bytes
	localparam logic [7:0] FIFO_DEPTH = 8'h80;
	localparam logic [7:0] WM_HIGH_0 = 8'h7C;
	localparam logic [7:0] WM_HIGH_1 = 8'h78;
	localparam logic [7:0] WM_HIGH_2 = 8'h70;
	localparam logic [7:0] WM_HIGH_3 = 8'h60;
	localparam logic [7:0] WM_LOW_0 = 8'h04;
	localparam logic [7:0] WM_LOW_1 = 8'h08;
	localparam logic [7:0] WM_LOW_2 = 8'h10;
	localparam logic [7:0] WM_LOW_3 = 8'h20;

	// Next-slot grid
	localparam real CLK_PERIOD_NS = 25.0;
	localparam real SLOT_SHORT_US = 18.88;
	localparam real SLOT_LONG_US = 37.77;
	localparam logic [10:0] SLOT_SHORT_CYC = 11'(int'($ceil(SLOT_SHORT_US * 1000.0 / CLK_PERIOD_NS)));
	localparam logic [10:0] SLOT_LONG_CYC = 11'(int'($ceil(SLOT_LONG_US * 1000.0 / CLK_PERIOD_NS)));
	localparam logic [10:0] SLOT_ONE = 11'h001;

	typedef enum logic {
		SLOT_IDLE,
		SLOT_RUN
	} pofr_slot_state_type;
endpackage : pofr_pkg
`default_nettype wire

// ### core/pofr_top.sv
// The Wishbone slave port was chosen for this implementation.
`default_nettype none
module pofr_top (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Receive side
	input wire logic rx_sof_i,
	input wire logic rx_done_i,
	input wire logic rx_parity_err_i,
	input wire logic [7:0] rx_sel_code_i,
	output logic rx_short_reply_o,
	output logic rx_broken_byte_o,
	// Transmit side
	input wire logic tx_active_i,
	input wire logic tx_done_i,
	input wire logic tx_bit_req_i,
	input wire logic tx_fifo_bit_i,
	input wire logic tx_raw_bit_i,
	output logic tx_fifo_pop_o,
	output logic tx_encoder_bit_o,
	// Collision detection
	input wire logic bit_window_i,
	input wire logic sub_pulse_i,
	output logic coll_err_o,
	// FIFO and slot timing
	input wire logic [7:0] fifo_count_i,
	input wire logic next_slot_i,
	output logic slot_tick_o,
	// Interrupt
	output logic irq_o
);
	import pofr_pkg::*;

	localparam int SLOT_MAX_WAIT = 1600;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [7:0] proto;
		logic [7:0] thresh;
		logic [7:0] status;
		logic [7:0] irq_en;
		logic rx_busy;
		pofr_slot_state_type slot;
		logic [10:0] slot_cnt;
		logic slot_tick;
		logic enc_bit;
		logic broken;
	} pofr_top_state_type;

	pofr_top_state_type st;
	pofr_top_state_type next_st;
	pofr_cfg_if cfg ();
	logic rst_all;
	logic taken;
	logic [5:0] idx;
	logic wr;
	logic fifo_evt;
	logic coll_evt;
	logic [7:0] events;

	function automatic logic is_sel_code(input logic [7:0] code);
		is_sel_code = (code == 8'h93) || (code == 8'h95) || (code == 8'h97);
	endfunction : is_sel_code

	assign rst_all = rst_i || !en_i;
	assign taken = wb_cyc_i && wb_stb_i && !st.ack;
	assign idx = wb_adr_i[7:2];
	assign wr = taken && wb_we_i && wb_sel_i[0];

	assign cfg.parity_dis = st.proto[PO_PARITY_DIS];
	assign cfg.pulse_six = st.proto[PO_PULSE_SIX];
	assign cfg.wm_high = st.thresh[FT_HIGH_LSB +: 2];
	assign cfg.wm_low = st.thresh[FT_LOW_LSB +: 2];

	pofr_fifo_level u_level (
		.clk_i(clk_i),
		.rst_i(rst_all),
		.cfg(cfg.dst),
		.rx_busy_i(st.rx_busy),
		.tx_busy_i(tx_active_i),
		.fifo_count_i(fifo_count_i),
		.fifo_evt_o(fifo_evt)
	);

	pofr_coll_count u_coll (
		.clk_i(clk_i),
		.rst_i(rst_all),
		.cfg(cfg.dst),
		.bit_window_i(bit_window_i),
		.sub_pulse_i(sub_pulse_i),
		.coll_err_o(coll_err_o),
		.coll_evt_o(coll_evt)
	);

	always_comb begin
		next_st = st;
		events = '0;
		events[ST_TX_END] = tx_done_i;
		events[ST_RX_START] = rx_sof_i;
		events[ST_FIFO] = fifo_evt;
		events[ST_RX_END] = rx_done_i;
		events[ST_COLL] = coll_evt;
		events[ST_PARITY] = rx_parity_err_i && st.rx_busy && !cfg.parity_dis;

		// Reception in progress
		if (rx_sof_i) begin
			next_st.rx_busy = 1'b1;
		end else if (rx_done_i) begin
			next_st.rx_busy = 1'b0;
			next_st.status[ST_RX_START] = 1'b0;
		end

		// Bus handshake and register access
		next_st.ack = taken;
		if (taken) begin
			next_st.dat = '0;
			case (idx)
				IDX_IRQ_STATUS: begin
					next_st.dat[7:0] = st.status;
					if (!wb_we_i) begin
						next_st.status = '0;
					end
				end
				IDX_PROTO_OPT: next_st.dat[7:0] = st.proto;
				IDX_RX_MIRROR: next_st.dat[MIRROR_BIT] = st.status[ST_RX_START];
				IDX_FIFO_THRESH: next_st.dat[7:0] = st.thresh;
				IDX_IRQ_ENABLE: next_st.dat[7:0] = st.irq_en;
				default: next_st.dat = '0;
			endcase
		end
		if (wr) begin
			case (idx)
				IDX_PROTO_OPT: next_st.proto = wb_dat_i[7:0] & PO_WRITE_MASK;
				IDX_FIFO_THRESH: next_st.thresh = wb_dat_i[7:0] & FT_WRITE_MASK;
				IDX_IRQ_CLEAR: next_st.status = next_st.status & ~wb_dat_i[7:0];
				IDX_IRQ_ENABLE: next_st.irq_en = wb_dat_i[7:0] & IRQ_GATE_MASK;
				default: next_st.proto = next_st.proto;
			endcase
		end
		// Set wins over any clear in the same cycle
		next_st.status = next_st.status | events;

		// Next-slot grid timer
		next_st.slot_tick = 1'b0;
		case (st.slot)
			SLOT_IDLE: begin
				if (next_slot_i) begin
					next_st.slot = SLOT_RUN;
					next_st.slot_cnt = st.proto[PO_SLOT_GRID] ? SLOT_LONG_CYC : SLOT_SHORT_CYC;
				end
			end
			SLOT_RUN: begin
				if (st.slot_cnt == SLOT_ONE) begin
					next_st.slot = SLOT_IDLE;
					next_st.slot_tick = 1'b1;
				end
				next_st.slot_cnt = st.slot_cnt - SLOT_ONE;
			end
			default: next_st.slot = SLOT_IDLE;
		endcase

		// Transmit bit source
		if (tx_bit_req_i) begin
			next_st.enc_bit = st.proto[PO_RAW_TX] ? tx_raw_bit_i : tx_fifo_bit_i;
		end

		// Anticollision framing
		next_st.broken = !st.proto[PO_PLAIN_FRAMING] && is_sel_code(rx_sel_code_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_all) begin
			st <= '0;
			st.proto <= PO_RESET;
			st.thresh <= FT_RESET;
			st.status <= ST_RESET;
			st.irq_en <= IRQ_EN_RESET;
			st.slot <= SLOT_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.dat;
	assign rx_short_reply_o = st.proto[PO_SHORT_REPLY];
	assign rx_broken_byte_o = st.broken;
	assign tx_fifo_pop_o = tx_bit_req_i && !st.proto[PO_RAW_TX];
	assign tx_encoder_bit_o = st.enc_bit;
	assign slot_tick_o = st.slot_tick;
	assign irq_o = |(st.status & st.irq_en & IRQ_GATE_MASK);

	AST_PARITY_OFF: assert property (@(posedge clk_i) disable iff (rst_all)
		$rose(st.status[ST_PARITY]) |-> $past(!st.proto[PO_PARITY_DIS] && rx_parity_err_i))
		else $error("Parity error reported while checking disabled");

	AST_SLOT_LOAD: assert property (@(posedge clk_i) disable iff (rst_all)
		(st.slot == SLOT_IDLE && next_slot_i) |=> st.slot_cnt
		== ($past(st.proto[PO_SLOT_GRID]) ? SLOT_LONG_CYC : SLOT_SHORT_CYC))
		else $error("Slot timer loaded with wrong grid");

	// Cycles spent in the running state
	logic [10:0] slot_age;

	always_ff @(posedge clk_i) begin
		if (rst_all || st.slot != SLOT_RUN) begin
			slot_age <= '0;
		end else begin
			slot_age <= slot_age + SLOT_ONE;
		end
	end

	AST_SLOT_WAIT: assert property (@(posedge clk_i) disable iff (rst_all)
		(st.slot == SLOT_RUN) |-> slot_age < 11'(SLOT_MAX_WAIT))
		else $error("Slot tick never came");

	AST_RAW_TX: assert property (@(posedge clk_i) disable iff (rst_all)
		(tx_bit_req_i && st.proto[PO_RAW_TX]) |=> tx_encoder_bit_o == $past(tx_raw_bit_i))
		else $error("Raw transmit bit not passed to encoder");

	AST_SHORT_REPLY: assert property (@(posedge clk_i) disable iff (rst_all)
		(wr && idx == IDX_PROTO_OPT) |=> rx_short_reply_o == $past(wb_dat_i[PO_SHORT_REPLY]))
		else $error("Short reply select did not follow write");

	AST_BROKEN: assert property (@(posedge clk_i) disable iff (rst_all)
		(is_sel_code(rx_sel_code_i) && !st.proto[PO_PLAIN_FRAMING]) |=> rx_broken_byte_o)
		else $error("Select code not framed with broken bytes");

	AST_MIRROR: assert property (@(posedge clk_i) disable iff (rst_all)
		(taken && !wb_we_i && idx == IDX_RX_MIRROR)
		|=> wb_ack_o && wb_dat_o[MIRROR_BIT] == $past(st.status[ST_RX_START]))
		else $error("Mirror bit differs from receive-start flag");

	AST_SOF_NO_IRQ: assert property (@(posedge clk_i) disable iff (rst_all)
		(rx_sof_i && st.status == ST_RESET && !events[ST_TX_END] && !events[ST_FIFO]
		&& !(|events[ST_RX_END:ST_PARITY])) |=> st.status[ST_RX_START] && !irq_o)
		else $error("Receive start raised the interrupt");

	AST_THRESH_RST: assert property (@(posedge clk_i)
		(rst_i || !en_i) |=> st.thresh == FT_RESET)
		else $error("Threshold register not cleared");

	AST_FIFO_STATUS: assert property (@(posedge clk_i) disable iff (rst_all)
		fifo_evt |=> st.status[ST_FIFO])
		else $error("FIFO event not latched");

	AST_READ_CLEAR: assert property (@(posedge clk_i) disable iff (rst_all)
		(taken && !wb_we_i && idx == IDX_IRQ_STATUS && events == ST_RESET)
		|=> st.status == ST_RESET && !irq_o)
		else $error("Status read did not clear the interrupt");

	AST_RESERVED: assert property (@(posedge clk_i) disable iff (rst_all)
		(wb_ack_o && (idx == IDX_PROTO_OPT || idx == IDX_FIFO_THRESH))
		|-> wb_dat_o[31:6] == 26'h0000000)
		else $error("Reserved bits read nonzero");
endmodule : pofr_top
`default_nettype wire

// ### sim/pofr_host_model.sv
`default_nettype none
module pofr_host_model (
	// Clock
	input wire logic clk_i,
	// Wishbone master
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [7:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_i,
	// Hang flag
	output logic tmo_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		{wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o, tmo_o} = '0;
	end

	// One classic cycle, held until ack, data taken at the ack edge
	task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= a;
		wb_sel_o <= 4'h1;
		wb_dat_o <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_i !== 1'b1 && n < 64);
		if (wb_ack_i !== 1'b1) tmo_o <= 1'b1;
		q = wb_dat_i[7:0];
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		@(posedge clk_i);
	endtask : acc
endmodule : pofr_host_model
`default_nettype wire

// ### sim/tb_pofr_top.sv
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_pofr_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic en_i = 1'b1;
	logic tx_active = 1'b0;
	logic [7:0] ev = 8'h00;
	logic [7:0] sel_code = 8'h00;
	logic [7:0] cnt = 8'h00;
	logic [7:0] q;
	logic [1:0] tsrc = 2'b00;
	logic wb_cyc, wb_stb, wb_we, wb_ack, tmo;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dw, wb_dr;
	logic pop, ebit, sshort, broken, coll, tick, irq;
	int error_cnt = 0;
	int comparisons = 0;
	int n;

	always #12.5 clk_i = ~clk_i;

	// Pulse bits: 0 sof, 1 rx end, 2 parity, 3 bit req, 4 window, 5 sub, 6 slot, 7 tx end
	pofr_top u_pofr_top (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dw), .wb_dat_o(wb_dr), .wb_ack_o(wb_ack), .rx_sof_i(ev[0]),
		.rx_done_i(ev[1]), .rx_parity_err_i(ev[2]), .rx_sel_code_i(sel_code),
		.rx_short_reply_o(sshort), .rx_broken_byte_o(broken), .tx_active_i(tx_active),
		.tx_done_i(ev[7]), .tx_bit_req_i(ev[3]), .tx_fifo_bit_i(tsrc[0]), .tx_raw_bit_i(tsrc[1]),
		.tx_fifo_pop_o(pop), .tx_encoder_bit_o(ebit), .bit_window_i(ev[4]),
		.sub_pulse_i(ev[5]), .coll_err_o(coll), .fifo_count_i(cnt), .next_slot_i(ev[6]),
		.slot_tick_o(tick), .irq_o(irq));

	pofr_host_model u_pofr_host_model (.clk_i(clk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
		.wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_dw),
		.wb_dat_i(wb_dr), .wb_ack_i(wb_ack), .tmo_o(tmo));

	task automatic tk(input int k);
		repeat (k) @(posedge clk_i);
	endtask : tk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_pofr_host_model.acc(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		u_pofr_host_model.acc(1'b0, a, 8'h00, q);
		`CHK($sformatf("register %0h", a), e, q & m)
	endtask : rd

	task automatic pulse(input logic [7:0] m);
		ev <= m;
		@(posedge clk_i);
		ev <= 8'h00;
		@(posedge clk_i);
	endtask : pulse

	task automatic txb(input logic p, input logic b);
		tsrc <= p ? {!b, b} : {b, !b};
		ev <= 8'h08;
		@(posedge clk_i);
		`CHK("fifo pop", p, pop)
		ev <= 8'h00;
		@(posedge clk_i);
		`CHK("encoder bit", b, ebit)
	endtask : txb

	task automatic fifo(input logic [7:0] c, input logic [7:0] e);
		cnt <= c;
		tk(3);
		rd(8'h30, 8'h20, e);
	endtask : fifo

	task automatic note(input string s);
		$display("Test %s done", s);
	endtask : note

	task automatic end_of_test();
		if (tmo === 1'b1) error_cnt++;
		$display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test

	always @(posedge tmo) end_of_test();

	initial begin
		tk(5);
		rst_i <= 1'b0;
		tk(1);
		rd(8'h40, 8'hFF, 8'h00);
		rd(8'h50, 8'hFF, 8'h00);
		wr(8'h50, 8'hFF);
		rd(8'h50, 8'hFF, 8'h0F);
		en_i <= 1'b0;
		tk(1);
		en_i <= 1'b1;
		tk(1);
		rd(8'h50, 8'hFF, 8'h00);
		wr(8'hFC, 8'hFF);
		rd(8'hFC, 8'hFF, 8'h00);
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'hFF, 8'h3F);
		note("reset");
		for (int s = 0; s < 2; s++) begin
			wr(8'h40, 8'(s));
			pulse(8'h10);
			repeat (6 - s) pulse(8'h20);
			`CHK("collision early", 1'b0, coll)
			pulse(8'h20);
			`CHK("collision", 1'b1, coll)
		end
		tk(1);
		`CHK("irq masked", 1'b0, irq)
		wr(8'h6C, 8'hFF);
		`CHK("irq enabled", 1'b1, irq)
		rd(8'h6C, 8'hFF, 8'hBC);
		wr(8'h68, 8'hFF);
		`CHK("irq cleared", 1'b0, irq)
		rd(8'h30, 8'hFF, 8'h00);
		note("collision");
		wr(8'h40, 8'h20);
		wr(8'h44, 8'h01);
		pulse(8'h01);
		pulse(8'h04);
		rd(8'h44, 8'hFF, 8'h01);
		`CHK("irq at start", 1'b0, irq)
		pulse(8'h02);
		tk(1);
		`CHK("irq at end", 1'b1, irq)
		rd(8'h30, 8'hFF, 8'h10);
		`CHK("irq after read", 1'b0, irq)
		rd(8'h44, 8'hFF, 8'h00);
		wr(8'h40, 8'h00);
		pulse(8'h01);
		pulse(8'h04);
		pulse(8'h02);
		rd(8'h30, 8'hFF, 8'h14);
		note("receive");
		for (int i = 0; i < 3; i++) begin
			sel_code <= 8'h93 + 8'(2 * i);
			tk(2);
			`CHK("broken byte", 1'b1, broken)
		end
		sel_code <= 8'h20;
		tk(2);
		`CHK("broken byte", 1'b0, broken)
		sel_code <= 8'h93;
		wr(8'h40, 8'h02);
		tk(1);
		`CHK("plain framing", 1'b0, broken)
		wr(8'h40, 8'h0C);
		`CHK("short reply", 1'b1, sshort)
		txb(1'b0, 1'b1);
		txb(1'b0, 1'b0);
		wr(8'h40, 8'h00);
		`CHK("short reply", 1'b0, sshort)
		txb(1'b1, 1'b0);
		txb(1'b1, 1'b1);
		note("options");
		// Grid times in 25 ns cycles, rounded up
		for (int g = 0; g < 2; g++) begin
			wr(8'h40, 8'(g << 4));
			ev <= 8'h40;
			@(posedge clk_i);
			ev <= 8'h00;
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
			end while (tick !== 1'b1 && n < 2000);
			// Tick launched at the grid edge is seen one edge later
			`CHK("slot cycles", g ? 1511 : 756, n - 1)
		end
		note("slot");
		for (int c = 0; c < 4; c++) begin
			wr(8'h50, 8'((c << 2) | c));
			pulse(8'h01);
			fifo(8'h80 - (8'h04 << c) - 8'h01, 8'h00);
			fifo(8'h80 - (8'h04 << c), 8'h20);
			pulse(8'h02);
			tx_active <= 1'b1;
			fifo((8'h04 << c) + 8'h01, 8'h00);
			fifo(8'h04 << c, 8'h20);
			tx_active <= 1'b0;
			cnt <= 8'h00;
			pulse(8'h80);
		end
		note("fifo");
		end_of_test();
	end
endmodule : tb_pofr_top
`default_nettype wire
